/* File: hdl/asl_result_status.v */
// Result and status logic of a multislope converter with a 4-wire serial port.
// Assumes chip select, serial clock, data in, oscillator and comparator all
// arrive asynchronously and are slower than a quarter of i_clk.
`timescale 1ns/100ps
`include "asl_defs.vh"
module asl_result_status (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_cs_n,
    input  wire       i_sclk,
    input  wire       i_din,
    input  wire       i_osc,
    input  wire       i_cmp_pos,
    output reg        o_dout,
    output wire       o_dout_oe,
    output reg        o_eoc,
    output reg        o_integrating,
    output reg        o_deint_active,
    output reg        o_deint_up,
    output reg        o_read_zero,
    output reg        o_sleep,
    output reg  [3:0] o_user_out_pins
);
    localparam N_SYNC = 5;
    localparam SY_CS = 0;
    localparam SY_SCLK = 1;
    localparam SY_DIN = 2;
    localparam SY_OSC = 3;
    localparam SY_CMP = 4;

    wire [N_SYNC-1:0] pin_in;
    wire [N_SYNC-1:0] pin_lvl;
    wire [N_SYNC-1:0] pin_rise;
    wire [N_SYNC-1:0] pin_fall;

    assign pin_in = {i_cmp_pos, i_osc, i_din, i_sclk, i_cs_n};

    genvar g;
    generate
        for (g = 0; g < N_SYNC; g = g + 1) begin : g_sync
            asl_pin_sync u_sync (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_pin   (pin_in[g]),
                .o_level (pin_lvl[g]),
                .o_rise  (pin_rise[g]),
                .o_fall  (pin_fall[g])
            );
        end
    endgenerate

    wire cs_active = ~pin_lvl[SY_CS];
    wire cs_start  = pin_fall[SY_CS];
    wire cs_end    = pin_rise[SY_CS];
    wire tick      = pin_rise[SY_OSC];
    wire cmp_pos   = pin_lvl[SY_CMP];

    // Command register 0 state
    reg        start_pending;
    reg        hz50;
    reg  [1:0] reg_select;
    // Serial shifters
    reg  [7:0] rx_shift;
    reg  [7:0] tx_shift;
    reg  [1:0] frame_sel;
    // Sequencing and results
    reg  [`ASL_SEQ_W-1:0] seq_count;
    reg  [`ASL_SEQ_W-1:0] next_count;
    reg  [1:0]            deint_idx;
    reg  signed [`ASL_ACC_W-1:0] acc;
    reg  signed [`ASL_ACC_W-1:0] result;
    reg                   coll_pending;
    reg                   collision;

    wire result_load = tick && (seq_count == `ASL_SEQ_LAST);
    wire conv_start  = tick && (seq_count == `ASL_SEQ_ZERO) && start_pending;

    // Sequence counter: parks at zero until a start is pending
    always @* begin
        next_count = seq_count;
        if (tick) begin
            if (seq_count != `ASL_SEQ_ZERO) begin
                next_count = seq_count + `ASL_SEQ_FIRST;
            end else if (start_pending) begin
                next_count = `ASL_SEQ_FIRST;
            end
        end
    end

    wire [`ASL_SEQ_W-1:0] int_end = `ASL_INT_START + (hz50 ? `ASL_INT_LEN_50 : `ASL_INT_LEN_60);
    wire                  at_zero    = (next_count == `ASL_SEQ_ZERO);
    wire                  int_after  = (next_count >= `ASL_INT_START);
    wire                  int_before = (next_count < int_end);

    // Deintegrate phase table
    reg                   di_hit;
    reg  [1:0]            di_hit_idx;
    reg  [`ASL_SEQ_W-1:0] di_max;
    reg  [`ASL_SUM_W-1:0] di_step;

    always @* begin
        di_hit     = 1'b1;
        di_hit_idx = 2'd0;
        case (seq_count)
            `ASL_DI1_START: di_hit_idx = 2'd0;
            `ASL_DI2_START: di_hit_idx = 2'd1;
            `ASL_DI3_START: di_hit_idx = 2'd2;
            `ASL_DI4_START: di_hit_idx = 2'd3;
            default:        di_hit     = 1'b0;
        endcase
    end

    always @* begin
        case (deint_idx)
            2'd0: begin
                di_max  = `ASL_DI1_MAX;
                di_step = `ASL_STEP_1;
            end
            2'd1: begin
                di_max  = `ASL_DI2_MAX;
                di_step = `ASL_STEP_2;
            end
            2'd2: begin
                di_max  = `ASL_DI3_MAX;
                di_step = `ASL_STEP_3;
            end
            default: begin
                di_max  = `ASL_DI4_MAX;
                di_step = `ASL_STEP_4;
            end
        endcase
    end

    // Accumulate with saturation at the hard overrange limit
    wire signed [`ASL_SUM_W-1:0] acc_wide = {acc[`ASL_ACC_W-1], acc};
    wire signed [`ASL_SUM_W-1:0] step_s   = di_step;
    wire signed [`ASL_SUM_W-1:0] hard_max = `ASL_HARD_MAX;
    // One bit of headroom so a step past the limit cannot wrap
    wire signed [`ASL_SUM_W-1:0] hard_min = -hard_max;
    reg  signed [`ASL_SUM_W-1:0] sum;
    reg  signed [`ASL_ACC_W-1:0] acc_next;

    always @* begin
        if (o_deint_up) begin
            sum = acc_wide + step_s;
        end else begin
            sum = acc_wide - step_s;
        end
    end

    always @* begin
        if (sum > hard_max) begin
            acc_next = hard_max[`ASL_ACC_W-1:0];
        end else if (sum < hard_min) begin
            acc_next = hard_min[`ASL_ACC_W-1:0];
        end else begin
            acc_next = sum[`ASL_ACC_W-1:0];
        end
    end

    // Zero crossing or the phase's longest count ends it
    wire deint_cross = (cmp_pos != o_deint_up);
    wire deint_limit = (seq_count == di_max);
    wire deint_done  = deint_cross || deint_limit;
    wire acc_step    = tick && o_deint_active;

    always @(posedge i_clk) begin
        if (i_rst) begin
            seq_count      <= `ASL_SEQ_ZERO;
            o_eoc          <= 1'b1;
            o_integrating  <= 1'b0;
            o_deint_active <= 1'b0;
            o_deint_up     <= 1'b0;
            deint_idx      <= 2'd0;
            acc            <= {`ASL_ACC_W{1'b0}};
            result         <= {`ASL_ACC_W{1'b0}};
        end else begin
            seq_count     <= next_count;
            o_eoc         <= at_zero;
            o_integrating <= int_after && int_before;
            if (conv_start) begin
                acc <= {`ASL_ACC_W{1'b0}};
            end else if (acc_step) begin
                acc <= acc_next;
            end
            if (tick) begin
                if (o_deint_active) begin
                    if (deint_done) begin
                        o_deint_active <= 1'b0;
                    end
                end else if (di_hit) begin
                    o_deint_active <= 1'b1;
                    deint_idx      <= di_hit_idx;
                    o_deint_up     <= cmp_pos;
                end
            end
            // Offset from the zero reading stays in the value
            if (result_load) begin
                result <= acc;
            end
        end
    end

    // Output byte selection
    reg [7:0] sel_byte;
    wire [7:0] status_byte = {collision, o_eoc, o_integrating, o_sleep,
                              result[`ASL_ACC_W-1], result[2:0]};

    always @* begin
        case (reg_select)
            `ASL_SEL_LOW:    sel_byte = result[10:3];
            `ASL_SEL_HIGH:   sel_byte = result[18:11];
            `ASL_SEL_STATUS: sel_byte = status_byte;
            default:         sel_byte = `ASL_INVALID_BYTE;
        endcase
    end

    // Enable follows the synced select, so it lags the pin by the sync delay
    assign o_dout_oe = cs_active;

    // Serial port: shift in on serial clock rise, out on fall
    always @(posedge i_clk) begin
        if (i_rst) begin
            rx_shift  <= 8'h00;
            tx_shift  <= 8'h00;
            o_dout    <= 1'b0;
            frame_sel <= `ASL_SEL_LOW;
        end else begin
            if (cs_start) begin
                tx_shift  <= sel_byte;
                o_dout    <= sel_byte[7];
                frame_sel <= reg_select;
            end else if (cs_active && pin_rise[SY_SCLK]) begin
                rx_shift <= {rx_shift[6:0], pin_lvl[SY_DIN]};
            end else if (cs_active && pin_fall[SY_SCLK]) begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                o_dout   <= tx_shift[6];
            end
        end
    end

    // Command registers latch on chip-select rise
    wire cmd_write = cs_end;
    wire cmd_pins  = cmd_write && rx_shift[`ASL_CMD_TARGET];
    wire cmd_ctl   = cmd_write && !rx_shift[`ASL_CMD_TARGET];

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_user_out_pins <= 4'h0;
            hz50            <= 1'b0;
            o_sleep         <= 1'b0;
            o_read_zero     <= 1'b0;
            reg_select      <= `ASL_SEL_LOW;
        end else begin
            if (cmd_pins) begin
                // Bit 4 drives the lowest pin; held until rewritten
                o_user_out_pins <= rx_shift[`ASL_CMD_PIN_MSB:`ASL_CMD_PIN_LSB];
            end
            if (cmd_ctl) begin
                hz50        <= rx_shift[`ASL_CMD0_HZ50];
                o_sleep     <= rx_shift[`ASL_CMD0_SLEEP];
                o_read_zero <= rx_shift[`ASL_CMD0_RZERO];
                reg_select  <= {rx_shift[`ASL_CMD0_RS1], rx_shift[`ASL_CMD0_RS0]};
            end
        end
    end

    // A new start written in the consuming cycle is kept
    wire start_write = cmd_ctl && rx_shift[`ASL_CMD0_START];

    always @(posedge i_clk) begin
        if (i_rst) begin
            start_pending <= 1'b0;
        end else if (start_write) begin
            start_pending <= 1'b1;
        end else if (conv_start) begin
            start_pending <= 1'b0;
        end
    end

    // Collision: result reload inside a frame is reported at its end
    wire load_in_frame = result_load && (cs_active || cs_start);
    wire status_frame  = (frame_sel == `ASL_SEL_STATUS);

    always @(posedge i_clk) begin
        if (i_rst) begin
            coll_pending <= 1'b0;
        end else if (load_in_frame) begin
            coll_pending <= 1'b1;
        end else if (cs_end) begin
            coll_pending <= 1'b0;
        end
    end

    // Set wins over the clear when both land on one chip-select rise
    always @(posedge i_clk) begin
        if (i_rst) begin
            collision <= 1'b0;
        end else if (cs_end && (coll_pending || result_load)) begin
            collision <= 1'b1;
        end else if (cs_end && status_frame) begin
            collision <= 1'b0;
        end
    end
endmodule // asl_result_status

/* File: hdl/asl_defs.vh */
// Constants for the converter result and status logic.
// Assumes inclusion by asl_result_status.v only; asl_pin_sync.v does not include it.
// Contract
// - Command bit 0 set selects pin register
// - Command bits 4..7 drive pins lowest upward
// - Reported value keeps offset, nothing subtracted
// - Select 00 reads result bits 3..10
// - Select 01 reads result bits 11..18
// - Two's complement, polarity bit 1 when negative
// - Result bits 0..2 in status, per conversion
// - Integrating flag high during input integration
// - Idle at count 0, end flag high
// - 2048 counts, end flag from 0000 to 0001
// - Result load during frame sets collision flag
// - Status read clears collision flag
// - Sequence counter times integration by preset counts
// - Deintegrate ends on comparator zero crossing
// - Results counter direction from phase polarity
// - Steps 512, 64, 8, 1 per phase
// - Counter copied to result at conversion end
// - Result saturates at plus/minus 350440
// - Result carries 19th magnitude bit
// - Select 10 reads status, 11 invalid
// - Command takes effect on chip-select rise
`ifndef ASL_DEFS_VH
`define ASL_DEFS_VH

`define ASL_SEQ_W          11
`define ASL_SEQ_LAST       11'h7FF
`define ASL_SEQ_ZERO       11'h000
`define ASL_SEQ_FIRST      11'h001
`define ASL_INT_START      11'h070
`define ASL_INT_LEN_60     11'h221
`define ASL_INT_LEN_50     11'h28F
`define ASL_DI1_START      11'h320
`define ASL_DI1_MAX        11'h5DC
`define ASL_DI2_START      11'h5F0
`define ASL_DI2_MAX        11'h654
`define ASL_DI3_START      11'h668
`define ASL_DI3_MAX        11'h6CC
`define ASL_DI4_START      11'h6E0
`define ASL_DI4_MAX        11'h744

`define ASL_ACC_W          20
`define ASL_SUM_W          21
`define ASL_STEP_1         21'h00_0200
`define ASL_STEP_2         21'h00_0040
`define ASL_STEP_3         21'h00_0008
`define ASL_STEP_4         21'h00_0001
`define ASL_HARD_MAX       21'h05_58E8

`define ASL_CMD_TARGET     0
`define ASL_CMD_PIN_LSB    4
`define ASL_CMD_PIN_MSB    7
`define ASL_CMD0_START     7
`define ASL_CMD0_HZ50      6
`define ASL_CMD0_SLEEP     5
`define ASL_CMD0_RZERO     4
`define ASL_CMD0_RS0       2
`define ASL_CMD0_RS1       1

`define ASL_SEL_LOW        2'h0
`define ASL_SEL_HIGH       2'h1
`define ASL_SEL_STATUS     2'h2
`define ASL_INVALID_BYTE   8'h00

`endif

/* File: hdl/asl_pin_sync.v */
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes an asynchronous pin input and the system clock.
`timescale 1ns/100ps
module asl_pin_sync (
    input  wire i_clk,
    input  wire i_rst,
    input  wire i_pin,
    output reg  o_level,
    output reg  o_rise,
    output reg  o_fall
);
    reg s1;
    reg s2;
    reg s3;

    // First stage feeds only the second; edges judged on stages two and three
    // Reset high so an idle-high select shows no false edge after reset
    always @(posedge i_clk) begin
        if (i_rst) begin
            s1      <= 1'b1;
            s2      <= 1'b1;
            s3      <= 1'b1;
            o_level <= 1'b1;
            o_rise  <= 1'b0;
            o_fall  <= 1'b0;
        end else begin
            s1     <= i_pin;
            s2     <= s1;
            s3     <= s2;
            o_rise <= (s2 == s3) && s3 && !o_level;
            o_fall <= (s2 == s3) && !s3 && o_level;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule // asl_pin_sync

/* File: test/asl_chk.sv */
// Port checks on the result and status logic.
// Assumes async pins slower than four clocks and a free oscillator.
`timescale 1ns/100ps
module asl_chk (
    input wire       i_clk,
    input wire       i_rst,
    input wire       i_cs_n,
    input wire       i_sclk,
    input wire       i_osc,
    input wire       o_dout,
    input wire       o_dout_oe,
    input wire       o_eoc,
    input wire       o_integrating,
    input wire       o_deint_active,
    input wire       o_deint_up,
    input wire [3:0] o_user_out_pins
);
    reg [11:0] icnt;
    reg [11:0] ecnt;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Raw ticks lead the synced ones, so bounds allow one either way
    always @(posedge i_clk) begin
        if (i_rst || !o_integrating) icnt <= 12'h000;
        else if ($rose(i_osc)) icnt <= icnt + 12'h001;
        if (i_rst || o_eoc) ecnt <= 12'h000;
        else if ($rose(i_osc)) ecnt <= ecnt + 12'h001;
    end
    pins_hold_a: assert property (!$stable(o_user_out_pins) |-> $past(i_cs_n, 3))
        else $error("pins changed inside a frame");
    oe_on_a: assert property (!i_cs_n [*8] |-> o_dout_oe)
        else $error("data out not driven while selected");
    oe_off_a: assert property (i_cs_n [*8] |-> !o_dout_oe)
        else $error("data out driven while deselected");
    dout_edge_a: assert property ($changed(o_dout) |-> !$past(i_sclk, 2))
        else $error("data out moved outside a clock low phase");
    eoc_idle_a: assert property (o_eoc |-> !o_integrating && !o_deint_active)
        else $error("phase active while conversion done");
    deint_dir_a: assert property (o_deint_active && $past(o_deint_active) |-> $stable(o_deint_up))
        else $error("direction changed inside a phase");
    int_len_a: assert property ($fell(o_integrating) |-> icnt inside {[544:546], [654:656]})
        else $error("integration length wrong");
    eoc_period_a: assert property ($rose(o_eoc) |-> ecnt inside {[2046:2048]})
        else $error("conversion length wrong");
    conv_done_c: cover property ($rose(o_eoc));
    pins_set_c: cover property (!$stable(o_user_out_pins));
    deint_c: cover property ($fell(o_deint_active));
endmodule // asl_chk
bind asl_result_status asl_chk chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
    .i_sclk(i_sclk), .i_osc(i_osc), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_eoc(o_eoc),
    .o_integrating(o_integrating), .o_deint_active(o_deint_active),
    .o_deint_up(o_deint_up), .o_user_out_pins(o_user_out_pins));

/* File: test/asl_host.sv */
// Processor model on the four-wire serial port.
// Assumes shift-in on clock rise, shift-out on fall, clock idle low.
`timescale 1ns/100ps
module asl_host (
    input  wire i_clk,
    input  wire i_hold,
    input  wire i_dout,
    input  wire i_dout_oe,
    output reg  o_cs_n,
    output reg  o_sclk,
    output reg  o_din
);
    localparam [47:0] sel_seq = 48'h0200_0406_0200;
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din  = 1'b1;
    end
    // Bit 0 of tx picks the target; i_hold gives a slow host
    task xfer(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            @(negedge i_clk);
            o_cs_n = 1'b0;
            #200;
            while (i_hold) #20;
            for (i = 7; i >= 0; i = i - 1) begin
                o_din = tx[i];
                #80 o_sclk = 1'b1;
                #80 rx[i] = i_dout_oe ? i_dout : 1'bx;
                o_sclk = 1'b0;
            end
            #160 o_cs_n = 1'b1;
            o_din = ~o_din;
            #400;
        end
    endtask
    // Status before and after the result bytes, so a collision shows
    task read_all(output [47:0] rd);
        reg [7:0] b;
        integer k;
        begin
            for (k = 5; k >= 0; k = k - 1) begin
                xfer(sel_seq[k*8 +: 8], b);
                rd[k*8 +: 8] = b;
            end
        end
    endtask
endmodule // asl_host

/* File: test/test_adc_result_status_logic.sv */
// Self-checking bench for the converter result and status logic.
// Assumes the host model drives the serial pins, the bench the rest.
`timescale 1ns/100ps
module test_adc_result_status_logic;
    reg        clk = 1'b0;
    reg        rst = 1'b1;
    reg        osc = 1'b0;
    reg        cmp = 1'b1;
    reg        hold = 1'b0;
    reg        flip = 1'b0;
    reg        dact_q = 1'b0;
    wire       cs_n, sclk, din, dout, dout_oe, eoc, integ, dact, dup, rz, slp;
    wire [3:0] pins;
    integer    err_count = 0;
    integer    total_checks = 0;
    integer    cyc = 0;
    reg [7:0]  rx;
    reg [47:0] rd;

    asl_result_status dut_u (.i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_din(din), .i_osc(osc), .i_cmp_pos(cmp), .o_dout(dout), .o_dout_oe(dout_oe),
        .o_eoc(eoc), .o_integrating(integ), .o_deint_active(dact), .o_deint_up(dup),
        .o_read_zero(rz), .o_sleep(slp), .o_user_out_pins(pins));
    asl_host host_u (.i_clk(clk), .i_hold(hold), .i_dout(dout), .i_dout_oe(dout_oe),
        .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        #20;
        forever #100 osc = ~osc;
    end
    // Flip the comparator once per phase so each phase takes a single step
    always @(negedge clk) begin
        dact_q <= dact;
        if (flip && dact && !dact_q) cmp <= ~cmp;
    end
    // Three conversions take about 64k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count = err_count + 1;
            end_of_test;
        end
    end

    task end_of_test;
        begin
            if (err_count == 0 && total_checks > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task check(input [79:0] name, input [7:0] exp, input [7:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("Error %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wait_eoc(input lvl);
        integer n;
        begin
            n = 0;
            while (eoc !== lvl && n < 30000) begin
                @(negedge clk);
                n = n + 1;
            end
            check("eoc", {7'h00, lvl}, {7'h00, eoc});
        end
    endtask
    task t_pins;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                host_u.xfer(8'h10 << i | 8'h01, rx);
                check("pins", 8'h01 << i, {4'h0, pins});
            end
            host_u.xfer(8'h08, rx);
            check("pins_hold", 8'h08, {4'h0, pins});
        end
    endtask
    // Comparator held still: every phase runs long and saturates
    task t_conv(input neg, input [7:0] cmd);
        reg [19:0] r;
        reg [19:0] v;
        reg [7:0]  st;
        reg        ovr;
        begin
            cmp = ~neg;
            r = neg ? 20'h0_0000 - 20'h5_58E8 : 20'h5_58E8;
            // Read frames rewrite command 0, so sleep reads back as 0
            st = {4'b0100, r[19], r[2:0]};
            host_u.xfer(cmd, rx);
            wait_eoc(1'b0);
            wait_eoc(1'b1);
            host_u.read_all(rd);
            // Host soft limit of 279040 counts either side
            v = {rd[35], rd[23:16], rd[31:24], rd[34:32]};
            ovr = rd[35] ? (v < 20'hB_BE00) : (v > 20'h4_4200);
            check("overrange", 8'h01, {7'h00, ovr});
            check("status", st, rd[39:32]);
            check("low", r[10:3], rd[31:24]);
            check("high", r[18:11], rd[23:16]);
            check("invalid", 8'h00, rd[15:8]);
            check("status2", st, rd[7:0]);
        end
    endtask
    // Phases of +512, -64, +8, -1 leave 455 in the result
    task t_coll;
        begin
            cmp = 1'b1;
            flip = 1'b1;
            host_u.xfer(8'hB2, rx);
            wait_eoc(1'b0);
            hold = 1'b1;
            fork
                host_u.xfer(8'h32, rx);
                begin
                    wait_eoc(1'b1);
                    repeat (20) @(negedge clk);
                    hold = 1'b0;
                end
            join
            flip = 1'b0;
            host_u.xfer(8'h32, rx);
            check("coll_set", 8'hD7, rx);
            host_u.xfer(8'h30, rx);
            check("coll_clr", 8'h57, rx);
            host_u.xfer(8'h30, rx);
            check("low_steps", 8'h38, rx);
            check("rz_slp", 8'h03, {6'h00, rz, slp});
        end
    endtask

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        t_pins;
        t_conv(1'b0, 8'h80);
        t_conv(1'b1, 8'hE4);
        t_coll;
        end_of_test;
    end
endmodule // test_adc_result_status_logic
